// *** verilog/enc_device.sv ***
`timescale 1ns/10ps
module enc_device (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic clk_en_in,
	input wire logic wire_count_strap,   // High selects 2-wire mode
	input wire logic test_mode_strap,    // Kept low in normal use
	input wire logic [7:0] angle_in,     // Measured angle
	input wire logic [5:0] field_in,     // Field strength code
	input wire logic [1:0] valid_in,     // Data valid bits
	input wire logic gain_loop_on_in,    // Gain loop enabled
	ssi_link_if.device link,
	output logic [4:0] last_cmd_out,     // Last command received
	output logic cmd_strobe_out          // Pulse when command complete
);
	// Two-flop synchronisers for the pins
	logic [1:0] sclk_s_reg, fs_s_reg, din_s_reg, strap_s_reg;
	logic sclk_d_reg;                    // Delayed synced clock, edge find
	logic [4:0] bit_cnt_reg;             // Clocks counted in this frame
	logic [4:0] cmd_reg;
	logic [15:0] shift_reg;              // Data bits to send
	logic drive_reg;                     // Output enable for the data pin
	logic dout_reg;
	logic [$clog2(enc_pkg::TIMEOUT_CYC+1)-1:0] idle_cnt_reg;
	logic sync_reg;                      // Internal frame select
	logic [7:0] angle_reg;               // Angle latched for the PWM
	logic [$clog2(enc_pkg::PWM_UNIT_CYC+1)-1:0] unit_cnt_reg;
	logic [8:0] pwm_pos_reg;             // Position within PWM period
	logic pwm_reg;

	wire sclk_rise = sclk_s_reg[1] & ~sclk_d_reg;
	wire sclk_fall = ~sclk_s_reg[1] & sclk_d_reg;
	wire two_wire = strap_s_reg[1];
	wire timed_out = (idle_cnt_reg ==
		$bits(idle_cnt_reg)'(enc_pkg::TIMEOUT_CYC));
	// Frame is open while the chosen select is high
	wire frame_open = two_wire ? sync_reg : fs_s_reg[1];
	wire last_cmd = (bit_cnt_reg == 5'(enc_pkg::CMD_BITS - 1));
	wire last_clk = (bit_cnt_reg == 5'(enc_pkg::FRAME_CLOCKS - 1));
	wire data_ok = gain_loop_on_in & (&valid_in);
	wire unit_tick = (unit_cnt_reg ==
		$bits(unit_cnt_reg)'(enc_pkg::PWM_UNIT_CYC - 1));
	wire pwm_wrap = (pwm_pos_reg == 9'(enc_pkg::PWM_PERIOD_UNITS - 1));

	// Pin synchronisers; first stage read by second only
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			sclk_s_reg <= 2'h0;
			fs_s_reg <= 2'h0;
			din_s_reg <= 2'h0;
			strap_s_reg <= 2'h0;
			sclk_d_reg <= 1'b0;
		end else if (clk_en_in) begin
			sclk_s_reg <= {sclk_s_reg[0], link.sclk};
			fs_s_reg <= {fs_s_reg[0], link.frame_sel};
			din_s_reg <= {din_s_reg[0], link.serial_data_io};
			strap_s_reg <= {strap_s_reg[0], wire_count_strap};
			sclk_d_reg <= sclk_s_reg[1];
		end
	end

	// Idle timer: any rising edge restarts it
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			idle_cnt_reg <= '0;
			sync_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (sclk_rise) begin
				idle_cnt_reg <= '0;
			end else if (!timed_out) begin
				idle_cnt_reg <= idle_cnt_reg + 1'b1;
			end
			// Select rises on timeout, ready for the next frame
			if (timed_out && two_wire) begin
				sync_reg <= 1'b1;
			end else if (!two_wire) begin
				sync_reg <= 1'b0;
			end
		end
	end

	// Serial shift engine; command sampled, data changed on rising edge
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			bit_cnt_reg <= 5'h0;
			cmd_reg <= 5'h0;
			shift_reg <= 16'h0000;
			drive_reg <= 1'b0;
			dout_reg <= 1'b0;
			cmd_strobe_out <= 1'b0;
			last_cmd_out <= 5'h00;
		end else if (clk_en_in) begin
			cmd_strobe_out <= 1'b0;
			// A rise clears the idle count in this same cycle, so the
			// first rise after a timeout must not be swallowed here
			if (!frame_open || (two_wire && timed_out && !sclk_rise)) begin
				// Idle or timed out: back to command phase, line free
				bit_cnt_reg <= 5'h0;
				drive_reg <= 1'b0;
			end else if (sclk_rise) begin
				if (bit_cnt_reg < 5'(enc_pkg::CMD_BITS)) begin
					// Command bits: pin stays an input
					cmd_reg <= {cmd_reg[3:0], din_s_reg[1]};
					bit_cnt_reg <= bit_cnt_reg + 5'h1;
					if (last_cmd) begin
						last_cmd_out <= {cmd_reg[3:0], din_s_reg[1]};
						cmd_strobe_out <= 1'b1;
						// Other commands need no serial answer here
						drive_reg <= ({cmd_reg[3:0], din_s_reg[1]}
							== enc_pkg::CMD_READ_ANGLE);
						shift_reg <= {valid_in, field_in, angle_in};
					end
				end else if (last_clk) begin
					// 22nd clock ends frame; 23rd is a new first
					bit_cnt_reg <= 5'h0;
					drive_reg <= 1'b0;
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 5'h1;
					if (bit_cnt_reg != 5'(enc_pkg::CMD_BITS)) begin
						shift_reg <= {shift_reg[14:0], 1'b0};
					end
				end
			end
			// Present current MSB on the line
			dout_reg <= shift_reg[15];
		end
	end

	// PWM unit timebase and period counter
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			unit_cnt_reg <= '0;
			pwm_pos_reg <= 9'h000;
			angle_reg <= 8'h00;
			pwm_reg <= 1'b0;
		end else if (clk_en_in) begin
			unit_cnt_reg <= unit_tick ? '0 : unit_cnt_reg + 1'b1;
			if (unit_tick) begin
				pwm_pos_reg <= pwm_wrap ? 9'h000 : pwm_pos_reg + 9'h001;
				if (pwm_wrap) begin
					angle_reg <= angle_in; // Latched per period, no glitch
				end
			end
			// High for angle+1 units of the 257-unit period
			pwm_reg <= data_ok && (pwm_pos_reg <= {1'b0, angle_reg});
		end
	end

	assign link.dev_data_o = dout_reg;
	assign link.dev_data_oe = drive_reg;
	assign link.sync_select_out = sync_reg;
	assign link.pwm = pwm_reg;
endmodule

// *** verilog/enc_pkg.sv ***
package enc_pkg;
	// Frame layout
	localparam int CMD_BITS = 5;
	localparam int VALID_BITS = 2;
	localparam int FIELD_BITS = 6;
	localparam int ANGLE_BITS = 8;
	localparam int FRAME_BITS = 21;
	localparam int DATA_BITS = 16;
	// Clocks in a continuous-readout frame before the next one starts
	localparam int FRAME_CLOCKS = 22;
	localparam logic [4:0] CMD_READ_ANGLE = 5'h00;
	// Core clock period in picoseconds
	localparam int CLK_PERIOD_PS = 5000;
	// Link timeout, least and most, in nanoseconds
	localparam int TIMEOUT_MIN_NS = 20000;
	localparam int TIMEOUT_MAX_NS = 24000;
	// Timeout detected at the least figure, rounded up
	localparam int TIMEOUT_CYC =
		(TIMEOUT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// PWM unit in picoseconds, longest rounding down
	localparam int PWM_UNIT_PS = 2260000;
	localparam int PWM_UNIT_CYC = PWM_UNIT_PS / CLK_PERIOD_PS;
	localparam int PWM_PERIOD_UNITS = 257;
	// Host clock divider half period in core cycles
	localparam int HOST_HALF_CYC = 16;
	// Host idle time for resync, a little past the longest timeout
	localparam int HOST_IDLE_CYC =
		(TIMEOUT_MAX_NS * 1000) / CLK_PERIOD_PS + 64;
endpackage

// *** verilog/ssi_link_if.sv ***
`timescale 1ns/10ps
interface ssi_link_if;
	logic sclk;           // Shift clock from the controller
	logic frame_sel;      // Frame select from the controller
	logic sync_select_out;// Internally made frame select, 2-wire mode
	logic dev_data_o;
	logic dev_data_oe;
	logic host_data_o;
	logic host_data_oe;
	logic pwm;
	// Resolved data line; pull-down when nobody drives
	wire serial_data_io = dev_data_oe ? dev_data_o :
		(host_data_oe ? host_data_o : 1'b0);
	modport device (input sclk, input frame_sel, input serial_data_io,
		output sync_select_out, output dev_data_o, output dev_data_oe,
		output pwm);
	modport host (output sclk, output frame_sel, input serial_data_io,
		input sync_select_out, output host_data_o, output host_data_oe,
		input pwm);
endinterface

// *** verilog/enc_host.sv ***
`timescale 1ns/10ps
module enc_host (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic clk_en_in,
	input wire logic two_wire_in,        // Link wired in 2-wire mode
	input wire logic start_in,           // Pulse: read one frame
	input wire logic [4:0] cmd_in,       // Command to send
	ssi_link_if.host link,
	output logic busy_out,
	output logic done_out,               // Pulse with new data
	output logic [15:0] data_out         // Valid, field, angle
);
	typedef enum logic [1:0] {IDLE, RUN, GAP} host_state_t;
	host_state_t state_reg;
	logic [1:0] din_s_reg;               // Synchroniser for data line
	logic [4:0] clk_cnt_reg;             // Clock pulses sent
	logic [4:0] cmd_reg;
	logic [15:0] rx_reg;
	logic [12:0] div_reg;                // Half period and idle timer
	logic sclk_reg;
	logic fs_reg;
	logic cmd_oe_reg;

	wire half_done = (div_reg == 13'(enc_pkg::HOST_HALF_CYC - 1));
	wire gap_done = (div_reg == 13'(enc_pkg::HOST_IDLE_CYC - 1));
	wire in_cmd = (clk_cnt_reg < 5'(enc_pkg::CMD_BITS));

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			din_s_reg <= 2'h0;
		end else if (clk_en_in) begin
			din_s_reg <= {din_s_reg[0], link.serial_data_io};
		end
	end

	// Frame sequencer: command out, 16 data in, then idle gap
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			state_reg <= IDLE;
			clk_cnt_reg <= 5'h0;
			cmd_reg <= 5'h00;
			rx_reg <= 16'h0000;
			div_reg <= 13'h0000;
			sclk_reg <= 1'b0;
			fs_reg <= 1'b0;
			cmd_oe_reg <= 1'b0;
			done_out <= 1'b0;
			data_out <= 16'h0000;
		end else if (clk_en_in) begin
			done_out <= 1'b0;
			case (state_reg)
				IDLE: begin
					div_reg <= 13'h0000;
					if (start_in) begin
						cmd_reg <= cmd_in;
						clk_cnt_reg <= 5'h0;
						fs_reg <= 1'b1;
						// Drive command only if not the default read
						cmd_oe_reg <= (cmd_in != enc_pkg::CMD_READ_ANGLE);
						state_reg <= RUN;
					end
				end
				RUN: begin
					div_reg <= half_done ? 13'h0000 : div_reg + 13'h0001;
					if (half_done) begin
						sclk_reg <= ~sclk_reg;
						if (!sclk_reg) begin
							// Rising edge: count it
							clk_cnt_reg <= clk_cnt_reg + 5'h1;
						end else begin
							// Falling edge: next command bit or sample
							if (in_cmd) begin
								cmd_reg <= {cmd_reg[3:0], 1'b0};
							end else if (clk_cnt_reg > 5'(enc_pkg::CMD_BITS) &&
								clk_cnt_reg < 5'(enc_pkg::FRAME_CLOCKS)) begin
								// Falls after rises 6..21 carry the 16 bits
								rx_reg <= {rx_reg[14:0], din_s_reg[1]};
							end
							if (clk_cnt_reg == 5'(enc_pkg::CMD_BITS)) begin
								cmd_oe_reg <= 1'b0;
							end
							if (clk_cnt_reg == 5'(enc_pkg::FRAME_CLOCKS)) begin
								state_reg <= GAP;
								fs_reg <= 1'b0;
							end
						end
					end
				end
				GAP: begin
					// Idle past the timeout to resync every frame
					div_reg <= div_reg + 13'h0001;
					if (gap_done) begin
						data_out <= rx_reg;
						done_out <= 1'b1;
						state_reg <= IDLE;
					end
				end
				default: state_reg <= IDLE;
			endcase
		end
	end

	assign busy_out = (state_reg != IDLE);
	assign link.sclk = sclk_reg;
	assign link.frame_sel = fs_reg & ~two_wire_in;
	assign link.host_data_o = cmd_reg[4];
	assign link.host_data_oe = cmd_oe_reg;
endmodule

// *** tb/ssi_link_properties.sv ***
`timescale 1ns/10ps
module ssi_link_properties (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic wire_count_strap,
	input wire logic sclk,
	input wire logic frame_sel,
	input wire logic sync_select_out,
	input wire logic dev_data_oe,
	input wire logic host_data_oe,
	input wire logic serial_data_io
);
	logic sclk_reg; // Shift clock one cycle ago
	logic [12:0] idle_reg; // Cycles since last rise, saturating
	logic [4:0] bit_reg; // Rises seen in this frame
	logic [4:0] cmd_reg; // Command bits seen on the wire
	wire rise = sclk && !sclk_reg;
	wire fall = !sclk && sclk_reg;
	wire [12:0] idle_next = (&idle_reg) ? idle_reg : idle_reg + 13'h0001;
	// 2-wire frames restart on a 4000-cycle idle, 3-wire on deselect
	wire restart = wire_count_strap ? (idle_reg >= 13'h0FA0) : !frame_sel;
	wire [4:0] bit_base = restart ? 5'h00 : bit_reg;
	// Rise 23 counts as rise 1 of the next frame
	wire [4:0] bit_next = (bit_base == 5'h16) ? 5'h01 : bit_base + 5'h01;
	// Edge finder, idle count and bit count
	always_ff @(posedge ref_clk_in) begin
		sclk_reg <= sclk;
		idle_reg <= (srst_in || rise) ? 13'h0000 : idle_next;
		bit_reg <= srst_in ? 5'h00 : (rise ? bit_next : bit_base);
	end
	// Command as the device should see it
	always_ff @(posedge ref_clk_in) begin
		if (rise && bit_base < 5'h05) begin
			cmd_reg <= {cmd_reg[3:0], serial_data_io};
		end
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);
	// Falls are checked, so the device's sync lag cannot matter
	sequence s_cmd_fall;
		fall && bit_reg inside {[5'h01:5'h04]};
	endsequence
	sequence s_data_fall;
		fall && bit_reg inside {[5'h05:5'h14]};
	endsequence
	AST_FLOAT_DESEL: assert property (
		(!wire_count_strap && !frame_sel)[*8] |-> !dev_data_oe)
		else $error("device drives while deselected");
	AST_CMD_FLOAT: assert property (s_cmd_fall |-> !dev_data_oe)
		else $error("device drives in command phase");
	AST_DATA_DRIVE: assert property (
		s_data_fall ##0 (cmd_reg == 5'h00) |-> dev_data_oe)
		else $error("device silent in data phase");
	AST_HOST_QUIET: assert property (s_data_fall |-> !host_data_oe)
		else $error("host drives in data phase");
	AST_SYNC_MADE: assert property (
		wire_count_strap && idle_reg == 13'h12C0 |-> sync_select_out)
		else $error("no frame select after idle");
	AST_SYNC_EARLY: assert property (
		$rose(sync_select_out) |-> idle_reg >= 13'h0FA0)
		else $error("frame select made too early");
	AST_SYNC_3W: assert property (
		(!wire_count_strap)[*4] |-> !sync_select_out)
		else $error("frame select made in 3-wire mode");
	AST_FS_LEN: assert property (
		!wire_count_strap && $fell(frame_sel) |->
		bit_reg inside {[5'h15:5'h16]})
		else $error("frame select dropped mid-frame");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got %h want %h", $time, a, b); end end
module tb;
	logic ref_clk_in = 1'b0; // 200 MHz core clock
	logic srst_in = 1'b1;
	logic strap = 1'b0; // High wires the link for 2-wire
	logic [7:0] angle = 8'h00;
	logic [5:0] field = 6'h00;
	logic [1:0] valid = 2'h0;
	logic gain = 1'b1;
	logic start = 1'b0;
	logic [4:0] cmd = 5'h00;
	logic [4:0] last_cmd;
	logic strobe, busy, done;
	logic [15:0] data;
	logic [31:0] seed = 32'h1CDF; // Fixed seed, repeatable run
	int error_cnt = 0;
	int n_checks = 0;
	int n_strobe = 0; // Command strobes seen
	int hi;
	ssi_link_if ssi_link_if_i();
	enc_device enc_device_i (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
		.clk_en_in(1'b1), .wire_count_strap(strap), .test_mode_strap(1'b0),
		.angle_in(angle), .field_in(field), .valid_in(valid),
		.gain_loop_on_in(gain), .link(ssi_link_if_i),
		.last_cmd_out(last_cmd), .cmd_strobe_out(strobe));
	enc_host enc_host_i (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
		.clk_en_in(1'b1), .two_wire_in(strap), .start_in(start),
		.cmd_in(cmd), .link(ssi_link_if_i), .busy_out(busy),
		.done_out(done), .data_out(data));
	ssi_link_properties ssi_link_properties_i (.ref_clk_in(ref_clk_in),
		.srst_in(srst_in), .wire_count_strap(strap),
		.sclk(ssi_link_if_i.sclk), .frame_sel(ssi_link_if_i.frame_sel),
		.sync_select_out(ssi_link_if_i.sync_select_out),
		.dev_data_oe(ssi_link_if_i.dev_data_oe),
		.host_data_oe(ssi_link_if_i.host_data_oe),
		.serial_data_io(ssi_link_if_i.serial_data_io));
	// Free-running core clock
	always #2.5 ref_clk_in = ~ref_clk_in;
	// Count command strobes
	always @(posedge ref_clk_in) begin
		if (strobe === 1'b1) begin
			n_strobe++;
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction
	// Other commands leave the line to the pull-down
	function automatic logic [15:0] want(input logic [4:0] c);
		return (c == 5'h00) ? {valid, field, angle} : 16'h0000;
	endfunction
	task automatic pick();
		seed = lfsr(seed);
		{valid, field, angle} = seed[15:0];
	endtask
	// One frame; entered and left at a falling edge
	task automatic rd(input logic [4:0] c);
		int k;
		int s0;
		s0 = n_strobe;
		cmd = c;
		start = 1'b1;
		@(negedge ref_clk_in);
		start = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 9000) begin
			@(negedge ref_clk_in);
			k++;
		end
		`CHK(done, 1'b1)
		`CHK(data, want(c))
		`CHK(last_cmd, c)
		`CHK(n_strobe, s0 + 1)
		k = 0;
		while (busy !== 1'b0 && k < 9000) begin
			@(negedge ref_clk_in);
			k++;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (6) @(negedge ref_clk_in);
		srst_in = 1'b0;
		{valid, field, angle} = 16'h0000;
		rd(5'h00);
		{valid, field, angle} = 16'hFFFF;
		rd(5'h00);
		for (int i = 0; i < 5; i++) begin
			pick();
			rd(5'h00);
		end
		for (int i = 0; i < 3; i++) begin
			pick();
			rd(seed[20:16] == 5'h00 ? 5'h1F : seed[20:16]);
		end
		// Invalid data: gain loop off, then valid bits clear
		for (int m = 0; m < 2; m++) begin
			{gain, valid} = (m == 0) ? 3'b011 : 3'b100;
			hi = 0;
			repeat (4) @(negedge ref_clk_in);
			repeat (1500) begin
				@(negedge ref_clk_in);
				hi += int'(ssi_link_if_i.pwm !== 1'b0);
			end
			`CHK(hi, 0)
		end
		gain = 1'b1;
		strap = 1'b1;
		repeat (5000) @(negedge ref_clk_in);
		`CHK(ssi_link_if_i.sync_select_out, 1'b1)
		for (int i = 0; i < 2; i++) begin
			pick();
			rd(5'h00);
		end
		tally_and_finish();
	end
	// Watchdog: the run needs about 75000 cycles, so stop at 95000
	initial begin
		#(95000 * 5);
		error_cnt++;
		tally_and_finish();
	end
endmodule
